// ===== src/rxu_pkg.sv
// package with register map, field positions and types of the serial receiver
package rxu_pkg;
	localparam logic [2:0] ADDR_STATUS_A  = 3'h0;
	localparam logic [2:0] ADDR_CONTROL_B = 3'h1;
	localparam logic [2:0] ADDR_CONTROL_C = 3'h2;
	localparam logic [2:0] ADDR_DATA      = 3'h3;
	localparam logic [2:0] ADDR_BAUD_LO   = 3'h4;
	localparam logic [2:0] ADDR_BAUD_HI   = 3'h5;
	// status a fields
	localparam int SA_RXC_POS = 7;
	localparam int SA_FRM_POS = 4;
	localparam int SA_OVR_POS = 3;
	localparam int SA_PAR_POS = 2;
	localparam int SA_U2X_POS = 1;
	// control b fields
	localparam int CB_IRQ_POS = 7;
	localparam int CB_ENA_POS = 4;
	localparam int CB_SZ2_POS = 2;
	localparam int CB_B8_POS  = 1;
	// control c fields
	localparam int CC_PM_HI  = 5;
	localparam int CC_PM_LO  = 4;
	localparam int CC_TSB_POS = 3;
	localparam int CC_SZ_HI  = 2;
	localparam int CC_SZ_LO  = 1;
	// reset values
	localparam logic [7:0]  STATUS_A_RESET  = 8'h00;
	localparam logic [7:0]  CONTROL_B_RESET = 8'h00;
	localparam logic [7:0]  CONTROL_C_RESET = 8'h06;
	localparam logic [11:0] BAUD_DIV_RESET  = 12'h000;
	// sampling: samples per bit and majority window
	localparam logic [3:0] NORM_PERIOD = 4'hF;
	localparam logic [3:0] NORM_VOTE_FIRST = 4'h8;
	localparam logic [3:0] DBL_PERIOD  = 4'h7;
	localparam logic [3:0] DBL_VOTE_FIRST = 4'h4;
	localparam logic [2:0] SIZE_NINE = 3'h7;
	localparam logic [3:0] BITS_MIN = 4'h5;
	localparam logic [3:0] BITS_NINE = 4'h9;
	localparam logic [3:0] BITS_EIGHT = 4'h8;

	typedef enum {RXU_IDLE, RXU_START, RXU_DATA, RXU_PARITY, RXU_STOP} rxu_state_e;

	typedef struct packed {
		logic       ninth;
		logic       framing;
		logic       overrun;
		logic       parity;
		logic [7:0] data;
	} rxu_entry_s;

	typedef struct packed {
		logic [3:0] nbits;
		logic       par_en;
		logic       par_odd;
		logic       dbl;
	} rxu_frame_cfg_s;
endpackage

// ===== src/rxu_receiver.sv
// asynchronous serial receiver with two-entry receive buffer and register port
// Function
// - each buffer entry keeps ninth bit and error flags; data read advances.
// - receive-complete flag is one exactly while unread entries exist.
// - clearing receiver enable flushes buffer and clears receive-complete.
// - interrupt request stays while receive-complete and its enable are set.
// - writes to error flag positions leave flags unchanged; software writes zeros.
// - error flags never raise an interrupt request.
// - framing flag reflects first stop bit only, ignoring two-stop setting.
// - overrun set when buffer full, character held, and new start detected.
// - overrun cleared when a frame moves into the receive buffer.
// - parity flag reads zero for frames received while parity checking is disabled.
// - parity mode upper bit enables check, lower bit selects odd.
// - parity flag per entry uses mode at arrival, valid until read.
// - clearing enable stops reception at once and releases the pin.
// - line sampled at sixteen times baud, eight times in double speed.
// - falling edge on idle line starts detection, first low is sample one.
// - start qualified by majority of samples 8-10 or 4-6, else rejected.
// - bit timing resynchronised at every valid start bit.
// - each data, parity, stop bit decided by majority of centre samples.
// - frame moves to buffer at first stop bit; second stop ignored.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module rxu_receiver #(
	parameter int DIV_W = 12
) (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       we_i,
	input  wire logic       re_i,
	output logic      [7:0] rdata_o,
	input  wire logic       serial_rx_pin_i,
	output logic            rx_irq_o,
	output logic            rx_pin_owned_o
);
	logic [7:0]       ctrl_b_q;
	logic [7:0]       ctrl_c_q;
	logic             dbl_q;
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_cnt_q;
	logic             tick_q;
	logic             rx_s1_q;
	logic             rx_s2_q;
	logic             line_prev_q;
	rxu_pkg::rxu_state_e  state_q;
	rxu_pkg::rxu_frame_cfg_s cfg_q;
	logic [3:0]       idx_q;
	logic [1:0]       vote_q;
	logic [3:0]       bitcnt_q;
	logic [8:0]       shreg_q;
	logic             pacc_q;
	logic             pbit_q;
	rxu_pkg::rxu_entry_s  fifo_q [2];
	logic             wptr_q;
	logic             rptr_q;
	logic [1:0]       count_q;
	logic             pend_q;
	rxu_pkg::rxu_entry_s  pend_entry_q;
	logic             ovr_q;
	logic             rx_irq_q;
	logic [7:0]       rdata_q;
	logic                 enable;
	logic [2:0]           size_sel;
	logic [3:0]           period;
	logic [3:0]           vote_first;
	logic [3:0]           vote_last;
	logic                 voted;
	logic                 in_window;
	logic                 start_seen;
	logic                 frame_done;
	logic                 overrun_evt;
	rxu_pkg::rxu_entry_s  new_entry;
	rxu_pkg::rxu_entry_s  head;
	rxu_pkg::rxu_frame_cfg_s cfg_now;
	logic [8:0]           aligned;
	logic                 pop;
	logic                 space;
	logic                 push;
	rxu_pkg::rxu_entry_s  push_entry;
	logic                 rx_complete;
	assign enable     = ctrl_b_q[rxu_pkg::CB_ENA_POS];
	assign size_sel   = {ctrl_b_q[rxu_pkg::CB_SZ2_POS],
		ctrl_c_q[rxu_pkg::CC_SZ_HI:rxu_pkg::CC_SZ_LO]};
	assign period     = cfg_q.dbl ? rxu_pkg::DBL_PERIOD : rxu_pkg::NORM_PERIOD;
	assign vote_first = cfg_q.dbl ? rxu_pkg::DBL_VOTE_FIRST : rxu_pkg::NORM_VOTE_FIRST;
	assign vote_last  = vote_first + 4'h2;
	assign in_window  = (idx_q >= vote_first) && (idx_q <= vote_last);
	// majority of two stored centre samples and the current one
	assign voted = (vote_q[0] & vote_q[1]) | ((vote_q[0] | vote_q[1]) & rx_s2_q);
	assign start_seen = enable && tick_q && (state_q == rxu_pkg::RXU_IDLE)
		&& line_prev_q && !rx_s2_q;
	assign rx_complete = (count_q != 2'h0);
	assign head = fifo_q[rptr_q];
	assign pop  = re_i && (addr_i == rxu_pkg::ADDR_DATA) && rx_complete;
	assign space = (count_q != 2'h2) || pop;
	assign overrun_evt = start_seen && pend_q && (count_q == 2'h2) && !pop;
	always_comb begin
		cfg_now.nbits = rxu_pkg::BITS_EIGHT;
		if (size_sel == rxu_pkg::SIZE_NINE) begin
			cfg_now.nbits = rxu_pkg::BITS_NINE;
		end else if (!size_sel[2]) begin
			cfg_now.nbits = rxu_pkg::BITS_MIN + {2'h0, size_sel[1:0]};
		end
		cfg_now.par_en  = ctrl_c_q[rxu_pkg::CC_PM_HI];
		cfg_now.par_odd = ctrl_c_q[rxu_pkg::CC_PM_LO];
		cfg_now.dbl     = dbl_q;
	end
	// data bits arrive lsb first at the top; shift down to align, upper bits zero
	assign aligned = shreg_q >> (4'h9 - cfg_q.nbits);
	assign frame_done = tick_q && (state_q == rxu_pkg::RXU_STOP) && (idx_q == vote_last);
	always_comb begin
		new_entry.ninth   = aligned[8];
		new_entry.data    = aligned[7:0];
		new_entry.framing = !voted;
		new_entry.parity  = cfg_q.par_en && (pbit_q != (pacc_q ^ cfg_q.par_odd));
		new_entry.overrun = 1'b0;
	end

	always_comb begin
		push       = 1'b0;
		push_entry = pend_entry_q;
		if (pend_q && space) begin
			push = 1'b1;
		end else if (!pend_q && frame_done && space) begin
			push       = 1'b1;
			push_entry = new_entry;
		end
		push_entry.overrun = ovr_q | overrun_evt;
	end
	// sample tick generator
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_cnt_q <= '0;
			tick_q    <= 1'b0;
		end else if (div_cnt_q == '0) begin
			div_cnt_q <= div_q;
			tick_q    <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q - 1'b1;
			tick_q    <= 1'b0;
		end
	end
	// pin synchroniser
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= serial_rx_pin_i;
			rx_s2_q <= rx_s1_q;
		end
	end
	// clock and data recovery
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q     <= rxu_pkg::RXU_IDLE;
			line_prev_q <= 1'b1;
			idx_q       <= 4'h0;
			vote_q      <= 2'h0;
			bitcnt_q    <= 4'h0;
			shreg_q     <= 9'h000;
			pacc_q      <= 1'b0;
			pbit_q      <= 1'b0;
			cfg_q       <= '0;
		end else if (!enable) begin
			state_q     <= rxu_pkg::RXU_IDLE;
			line_prev_q <= 1'b1;
		end else if (tick_q) begin
			if (in_window && (idx_q != vote_last)) begin
				vote_q <= {vote_q[0], rx_s2_q};
			end
			idx_q <= (idx_q == period) ? 4'h0 : idx_q + 4'h1;
			case (state_q)
				rxu_pkg::RXU_IDLE: begin
					line_prev_q <= rx_s2_q;
					if (start_seen) begin
						state_q  <= rxu_pkg::RXU_START;
						idx_q    <= 4'h2;
						cfg_q    <= cfg_now;
						bitcnt_q <= 4'h0;
						shreg_q  <= 9'h000;
						pacc_q   <= 1'b0;
					end
				end
				rxu_pkg::RXU_START: begin
					if ((idx_q == vote_last) && voted) begin
						state_q     <= rxu_pkg::RXU_IDLE;
						line_prev_q <= 1'b1;
					end else if (idx_q == period) begin
						state_q <= rxu_pkg::RXU_DATA;
					end
				end
				rxu_pkg::RXU_DATA: begin
					if (idx_q == vote_last) begin
						shreg_q  <= {voted, shreg_q[8:1]};
						pacc_q   <= pacc_q ^ voted;
						bitcnt_q <= bitcnt_q + 4'h1;
					end
					if ((idx_q == period) && (bitcnt_q == cfg_q.nbits)) begin
						state_q <= cfg_q.par_en ? rxu_pkg::RXU_PARITY : rxu_pkg::RXU_STOP;
					end
				end
				rxu_pkg::RXU_PARITY: begin
					if (idx_q == vote_last) begin
						pbit_q <= voted;
					end
					if (idx_q == period) begin
						state_q <= rxu_pkg::RXU_STOP;
					end
				end
				rxu_pkg::RXU_STOP: begin
					if (idx_q == vote_last) begin
						state_q     <= rxu_pkg::RXU_IDLE;
						line_prev_q <= voted;
					end
				end
				default: begin
					state_q <= rxu_pkg::RXU_IDLE;
				end
			endcase
		end
	end

	// receive buffer and held character
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fifo_q[0]    <= '0;
			fifo_q[1]    <= '0;
			wptr_q       <= 1'b0;
			rptr_q       <= 1'b0;
			count_q      <= 2'h0;
			pend_q       <= 1'b0;
			pend_entry_q <= '0;
		end else if (!enable) begin
			count_q <= 2'h0;
			wptr_q  <= 1'b0;
			rptr_q  <= 1'b0;
			pend_q  <= 1'b0;
		end else begin
			if (push) begin
				fifo_q[wptr_q] <= push_entry;
				wptr_q         <= ~wptr_q;
			end
			if (pop) begin
				rptr_q <= ~rptr_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
			if (frame_done && (pend_q ? push : !space)) begin
				pend_entry_q <= new_entry;
				pend_q       <= 1'b1;
			end else if (push && pend_q) begin
				pend_q <= 1'b0;
			end
		end
	end
	// overrun seen since last move into the buffer; an event never meets a move
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ovr_q <= 1'b0;
		end else if (!enable) begin
			ovr_q <= 1'b0;
		end else begin
			ovr_q <= overrun_evt || (ovr_q && !push);
		end
	end
	// register writes; error flag positions are not writable
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_b_q <= rxu_pkg::CONTROL_B_RESET;
			ctrl_c_q <= rxu_pkg::CONTROL_C_RESET;
			dbl_q    <= rxu_pkg::STATUS_A_RESET[rxu_pkg::SA_U2X_POS];
			div_q    <= rxu_pkg::BAUD_DIV_RESET[DIV_W-1:0];
		end else if (we_i) begin
			case (addr_i)
				rxu_pkg::ADDR_STATUS_A:  dbl_q <= wdata_i[rxu_pkg::SA_U2X_POS];
				rxu_pkg::ADDR_CONTROL_B: ctrl_b_q <= {wdata_i[7:2], 2'h0};
				rxu_pkg::ADDR_CONTROL_C: ctrl_c_q <= {2'h0, wdata_i[5:1], 1'b0};
				rxu_pkg::ADDR_BAUD_LO:   div_q[7:0] <= wdata_i;
				rxu_pkg::ADDR_BAUD_HI:   div_q[DIV_W-1:8] <= wdata_i[DIV_W-9:0];
				default: begin
				end
			endcase
		end
	end
	// read data, one cycle after the strobe
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_q <= 8'h00;
		end else if (re_i) begin
			case (addr_i)
				rxu_pkg::ADDR_STATUS_A: begin
					rdata_q <= 8'h00;
					rdata_q[rxu_pkg::SA_RXC_POS] <= rx_complete;
					rdata_q[rxu_pkg::SA_FRM_POS] <= rx_complete & head.framing;
					rdata_q[rxu_pkg::SA_OVR_POS] <= rx_complete & head.overrun;
					rdata_q[rxu_pkg::SA_PAR_POS] <= rx_complete & head.parity;
					rdata_q[rxu_pkg::SA_U2X_POS] <= dbl_q;
				end
				rxu_pkg::ADDR_CONTROL_B: begin
					rdata_q <= ctrl_b_q;
					rdata_q[rxu_pkg::CB_B8_POS] <= rx_complete & head.ninth;
				end
				rxu_pkg::ADDR_CONTROL_C: rdata_q <= ctrl_c_q;
				rxu_pkg::ADDR_DATA:      rdata_q <= rx_complete ? head.data : 8'h00;
				rxu_pkg::ADDR_BAUD_LO:   rdata_q <= div_q[7:0];
				rxu_pkg::ADDR_BAUD_HI:   rdata_q <= {{(16-DIV_W){1'b0}}, div_q[DIV_W-1:8]};
				default:                 rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// only the receive-complete state requests an interrupt
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_irq_q <= 1'b0;
		end else begin
			rx_irq_q <= ctrl_b_q[rxu_pkg::CB_IRQ_POS] && enable
				&& ((count_q + {1'b0, push} - {1'b0, pop}) != 2'h0);
		end
	end

	assign rdata_o        = rdata_q;
	assign rx_irq_o       = rx_irq_q;
	assign rx_pin_owned_o = ctrl_b_q[rxu_pkg::CB_ENA_POS];
endmodule
`default_nettype wire

// ===== sim/rxu_tx_model.sv
// serial transmitter model driving the receive line
`timescale 1ns/100ps
`default_nettype none
module rxu_tx_model (
	input  wire logic clk_i,
	output logic      line_o
);
	initial line_o = 1'b1;
	// lsb first, each bit held spb clocks, then idle high
	task automatic send(input logic [13:0] bits, input int len, input int spb);
		for (int i = 0; i < len; i++) begin
			line_o <= bits[i];
			repeat (spb) @(posedge clk_i);
		end
		line_o <= 1'b1;
		@(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// ===== sim/rxu_checker.sv
// port checker for the serial receiver
`timescale 1ns/100ps
`default_nettype none
module rxu_checker (
	input wire logic       clk_i,
	input wire logic       arst_n_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       we_i,
	input wire logic       re_i,
	input wire logic [7:0] rdata_o,
	input wire logic       serial_rx_pin_i,
	input wire logic       rx_irq_o,
	input wire logic       rx_pin_owned_o
);
	logic cb_wr;
	logic pop;
	assign cb_wr = we_i && addr_i == rxu_pkg::ADDR_CONTROL_B;
	assign pop = re_i && addr_i == rxu_pkg::ADDR_DATA;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	reset_clean_a:
	assert property ($rose(arst_n_i) |-> !rx_irq_o && !rx_pin_owned_o && rdata_o == 8'h00)
		else $error("outputs not clear after reset");
	owned_follow_a:
	assert property (cb_wr |=> rx_pin_owned_o == $past(wdata_i[rxu_pkg::CB_ENA_POS]))
		else $error("pin ownership not following enable");
	owned_hold_a:
	assert property (!cb_wr |=> $stable(rx_pin_owned_o)) else $error("pin ownership moved");
	irq_needs_en_a:
	assert property (rx_irq_o |-> $past(rx_pin_owned_o)) else $error("irq with receiver off");
	flush_irq_a:
	assert property (cb_wr && !wdata_i[rxu_pkg::CB_ENA_POS] |=> ##1 !rx_irq_o)
		else $error("irq survived disable");
	irq_drop_a:
	assert property ($fell(rx_irq_o) |-> $past(pop || cb_wr) || $past(pop || cb_wr, 2))
		else $error("irq dropped without cause");
	rxc_seen_a:
	assert property (re_i && addr_i == rxu_pkg::ADDR_STATUS_A && rx_irq_o
		|=> rdata_o[rxu_pkg::SA_RXC_POS]) else $error("complete flag low while irq");
	irq_mask_a:
	assert property (cb_wr && !wdata_i[rxu_pkg::CB_IRQ_POS] |=> ##1 !rx_irq_o)
		else $error("irq while masked");
	cover property ($rose(rx_irq_o));
	cover property (pop && rx_irq_o);
	cover property (cb_wr && rx_irq_o);
endmodule
bind rxu_receiver rxu_checker i_chk (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
	.re_i(re_i), .rdata_o(rdata_o), .serial_rx_pin_i(serial_rx_pin_i), .rx_irq_o(rx_irq_o),
	.rx_pin_owned_o(rx_pin_owned_o)
);
`default_nettype wire

// ===== sim/rxu_receiver_tb_top.sv
// self-checking bench for the serial receiver
`timescale 1ns/100ps
`default_nettype none
module rxu_receiver_tb_top;
	localparam logic [2:0] SA = rxu_pkg::ADDR_STATUS_A;
	localparam logic [2:0] CB = rxu_pkg::ADDR_CONTROL_B;
	localparam logic [2:0] CC = rxu_pkg::ADDR_CONTROL_C;
	localparam logic [2:0] DB = rxu_pkg::ADDR_DATA;
	logic       clk_i = 1'b0;
	logic       arst_n_i = 1'b0;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       we_i = 1'b0;
	logic       re_i = 1'b0;
	logic [7:0] rdata_o;
	logic       line;
	logic       rx_irq_o;
	logic       rx_pin_owned_o;
	int         errors = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	int         pms[4] = '{2, 3, 6, 7};
	always #5 clk_i = ~clk_i;
	rxu_tx_model i_tx (.clk_i(clk_i), .line_o(line));
	rxu_receiver i_dut (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .serial_rx_pin_i(line),
		.rx_irq_o(rx_irq_o), .rx_pin_owned_o(rx_pin_owned_o)
	);
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge clk_i);
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge clk_i);
		re_i <= 1'b0;
		@(posedge clk_i);
		chk($sformatf("register %0d", a), rdata_o, e);
	endtask
	// pm: bit1 parity on, bit0 odd, bit2 corrupt the parity bit
	task automatic tx(input logic [8:0] d, input int nd, input int pm, input logic st,
		input int spb);
		logic [13:0] b;
		int          n;
		b = 14'h0000;
		for (int i = 0; i < nd; i++) begin
			b[i + 1] = d[i];
		end
		n = nd + 1;
		if (pm[1]) begin
			b[n] = ^d ^ pm[0] ^ pm[2];
			n++;
		end
		b[n] = st;
		i_tx.send(b, n + 1, spb);
		repeat (4) @(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		rd(CB, 8'h00);
		rd(CC, 8'h06);
		rd(SA, 8'h00);
		rd(DB, 8'h00);
		wr(CB, 8'h90);
		tx(9'h0A5, 8, 0, 1'b1, 16);
		chk("irq", {7'h00, rx_irq_o}, 8'h01);
		rd(SA, 8'h80);
		rd(DB, 8'hA5);
		rd(SA, 8'h00);
		chk("irq", {7'h00, rx_irq_o}, 8'h00);
		foreach (pms[k]) begin
			wr(CC, 8'h06 | 8'(pms[k][1:0]) << 4);
			tx(9'h06B, 8, pms[k], 1'b1, 16);
			rd(SA, 8'h80 | 8'(pms[k][2]) << 2);
			rd(DB, 8'h6B);
		end
		wr(CC, 8'h00);
		tx(9'h1FF, 5, 0, 1'b1, 16);
		rd(DB, 8'h1F);
		wr(CB, 8'h94);
		wr(CC, 8'h06);
		tx(9'h1A5, 9, 0, 1'b1, 16);
		tx(9'h0C3, 9, 0, 1'b1, 16);
		rd(CB, 8'h96);
		rd(DB, 8'hA5);
		rd(CB, 8'h94);
		rd(DB, 8'hC3);
		wr(CB, 8'h90);
		for (int k = 1; k < 5; k++) begin
			tx(9'(k * 17), 8, 0, 1'b1, 16);
		end
		rd(SA, 8'h80);
		rd(DB, 8'h11);
		rd(SA, 8'h80);
		rd(DB, 8'h22);
		rd(SA, 8'h88);
		rd(DB, 8'h33);
		rd(SA, 8'h00);
		tx(9'h055, 8, 0, 1'b1, 16);
		rd(SA, 8'h80);
		rd(DB, 8'h55);
		wr(SA, 8'h02);
		tx(9'h096, 8, 0, 1'b1, 8);
		rd(SA, 8'h82);
		rd(DB, 8'h96);
		wr(SA, 8'h00);
		i_tx.send(14'h0000, 1, 6);
		repeat (20) @(posedge clk_i);
		tx(9'h03A, 8, 0, 1'b1, 16);
		rd(DB, 8'h3A);
		rd(SA, 8'h00);
		wr(CB, 8'h10);
		wr(CC, 8'h0E);
		tx(9'h077, 8, 0, 1'b0, 16);
		chk("irq", {7'h00, rx_irq_o}, 8'h00);
		wr(SA, 8'h1C);
		rd(SA, 8'h90);
		wr(CB, 8'h90);
		@(posedge clk_i);
		chk("irq", {7'h00, rx_irq_o}, 8'h01);
		wr(CB, 8'h00);
		chk("owned", {7'h00, rx_pin_owned_o}, 8'h00);
		rd(SA, 8'h00);
		wr(CB, 8'h90);
		fork
			tx(9'h0F0, 8, 0, 1'b1, 16);
			begin
				repeat (60) @(posedge clk_i);
				wr(CB, 8'h00);
			end
		join
		wr(CB, 8'h90);
		rd(SA, 8'h00);
		close_out();
	end
endmodule
`default_nettype wire
